// ---- odtzq_ctrl.sv ----
// Host sequencer for calibration, termination pulses and leveling entry.
// Assumes the user holds a request until o_ack and the device pins
// are sampled on the same 40 MHz clock.
`timescale 1ns/1ps
`include "odtzq_defs.svh"

module odtzq_ctrl (
	// Clock and reset
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst_n,
	// User request
	input  wire logic                 i_req_valid,
	input  wire odtzq_pkg::odtzq_cmd_t i_req_cmd,
	input  wire logic                 i_req_full_burst,
	input  wire logic [3:0]           i_write_latency,
	output logic                      o_ready,
	output logic                      o_ack,
	// Device pins
	output odtzq_pkg::odtzq_cmd_t     o_cmd,
	output logic                      o_cke,
	output logic                      o_odt,
	output logic                      o_dqs,
	output logic                      o_dqs_oe_n
);

	localparam logic [9:0] INIT_CAL  = 10'(`ODTZQ_INIT_CAL_NCK);
	localparam logic [9:0] LONG_CAL  = 10'(`ODTZQ_LONG_CAL_NCK);
	localparam logic [9:0] SHORT_CAL = 10'(`ODTZQ_SHORT_CAL_NCK);
	localparam logic [9:0] LVL_EN    = 10'(`ODTZQ_LVL_STROBE_EN_NCK);
	localparam logic [9:0] LVL_STB   = 10'(`ODTZQ_LVL_FIRST_STB_NCK
		- `ODTZQ_LVL_STROBE_EN_NCK);
	localparam logic [9:0] DLL_LOCK  = 10'(`ODTZQ_DLL_LOCK_NCK);
	localparam logic [3:0] ODT_SHORT = 4'(`ODTZQ_TERM_HIGH_SHORT_NCK);
	localparam logic [3:0] ODT_FULL  = 4'(`ODTZQ_TERM_HIGH_FULL_NCK);
	localparam logic [1:0] REF_PD    = 2'(`ODTZQ_REF_PD_NCK);
	localparam logic [3:0] STB_MAX   = 4'(`ODTZQ_STABLE_MAX);
	localparam logic [3:0] PD_SUB    = 4'(`ODTZQ_TERM_PD_WL_SUB);
	localparam logic [4:0] WR_BURST  = 5'(`ODTZQ_WR_PD_BURST_NCK);

	odtzq_pkg::odtzq_ctrl_t s_r;
	odtzq_pkg::odtzq_ctrl_t s_nxt;

	logic       timer_load;
	logic [9:0] timer_val;
	logic       timer_done;
	logic [9:0] wr_rec_cyc;
	logic [9:0] dll_exit_cyc;
	logic [3:0] wl_m1;
	logic       take;
	logic       rd_ok;
	logic       wr_ok;
	logic       pd_ok;

	odtzq_timer u_timer (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_load     (timer_load),
		.i_value    (timer_val),
		.o_done     (timer_done)
	);

	always_comb begin
		wr_rec_cyc   = odtzq_pkg::odtzq_ns_to_cyc(`ODTZQ_WR_REC_NS,
			`ODTZQ_WR_REC_NCK);
		dll_exit_cyc = odtzq_pkg::odtzq_ns_to_cyc(`ODTZQ_DLL_EXIT_NS,
			`ODTZQ_DLL_EXIT_NCK);
		wl_m1 = i_write_latency - PD_SUB;
		// Synchronous termination needs a locked loop too
		rd_ok = (s_r.dll_cnt == 10'h000);
		wr_ok = rd_ok && (s_r.stable >= wl_m1);
		// Refresh may still run inside; only spacing is enforced
		pd_ok = (s_r.wrpd_cnt == 5'h00) && (s_r.refpd_cnt == 2'h0)
			&& (s_r.odt_cnt == 4'h0) && !s_r.odt
			&& (s_r.stable >= wl_m1);
		take = i_req_valid && s_r.ready;
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.ack  = 1'b0;
		s_nxt.cmd  = odtzq_pkg::ODTZQ_C_NOP;
		s_nxt.dqs  = 1'b0;
		timer_load = 1'b0;
		timer_val  = 10'h000;
		if (s_r.dqs) begin
			s_nxt.dqs_oe_n = 1'b1;
		end
		if (s_r.dll_cnt != 10'h000) begin
			s_nxt.dll_cnt = s_r.dll_cnt - 10'h001;
		end
		if (s_r.wrpd_cnt != 5'h00) begin
			s_nxt.wrpd_cnt = s_r.wrpd_cnt - 5'h01;
		end
		if (s_r.refpd_cnt != 2'h0) begin
			s_nxt.refpd_cnt = s_r.refpd_cnt - 2'h1;
		end
		if (s_r.stable != STB_MAX) begin
			s_nxt.stable = s_r.stable + 4'h1;
		end
		if (s_r.odt_cnt != 4'h0) begin
			s_nxt.odt_cnt = s_r.odt_cnt - 4'h1;
			if (s_r.odt_cnt == 4'h1) begin
				s_nxt.odt    = 1'b0;
				s_nxt.stable = 4'h0;
			end
		end
		case (s_r.st)
			odtzq_pkg::ODTZQ_S_INIT: begin
				s_nxt.cke     = 1'b1;
				s_nxt.cmd     = odtzq_pkg::ODTZQ_C_ZQ_INIT;
				timer_load    = 1'b1;
				timer_val     = INIT_CAL;
				s_nxt.dll_cnt = DLL_LOCK;
				s_nxt.st      = odtzq_pkg::ODTZQ_S_WAIT;
			end
			odtzq_pkg::ODTZQ_S_WAIT: begin
				// Nothing is issued until the interval runs out
				if (timer_done) begin
					s_nxt.st    = odtzq_pkg::ODTZQ_S_IDLE;
					s_nxt.ready = 1'b1;
				end
			end
			odtzq_pkg::ODTZQ_S_IDLE: begin
				if (take) begin
					case (i_req_cmd)
						odtzq_pkg::ODTZQ_C_ZQ_LONG: begin
							s_nxt.cmd   = i_req_cmd;
							s_nxt.ack   = 1'b1;
							s_nxt.ready = 1'b0;
							timer_load  = 1'b1;
							timer_val   = LONG_CAL;
							s_nxt.st    = odtzq_pkg::ODTZQ_S_WAIT;
						end
						odtzq_pkg::ODTZQ_C_ZQ_SHORT: begin
							s_nxt.cmd   = i_req_cmd;
							s_nxt.ack   = 1'b1;
							s_nxt.ready = 1'b0;
							timer_load  = 1'b1;
							timer_val   = SHORT_CAL;
							s_nxt.st    = odtzq_pkg::ODTZQ_S_WAIT;
						end
						odtzq_pkg::ODTZQ_C_LVL: begin
							s_nxt.cmd   = i_req_cmd;
							s_nxt.ack   = 1'b1;
							s_nxt.ready = 1'b0;
							timer_load  = 1'b1;
							timer_val   = LVL_EN;
							s_nxt.st    = odtzq_pkg::ODTZQ_S_LVL_EN;
						end
						odtzq_pkg::ODTZQ_C_WRITE: begin
							// Pulse length covers the burst
							if (wr_ok) begin
								s_nxt.cmd     = i_req_cmd;
								s_nxt.ack     = 1'b1;
								s_nxt.odt     = 1'b1;
								s_nxt.stable  = 4'h0;
								s_nxt.odt_cnt = i_req_full_burst ?
									ODT_FULL : ODT_SHORT;
								s_nxt.wrpd_cnt = 5'(i_write_latency)
									+ WR_BURST + wr_rec_cyc[4:0];
							end
						end
						odtzq_pkg::ODTZQ_C_READ: begin
							if (rd_ok) begin
								s_nxt.cmd = i_req_cmd;
								s_nxt.ack = 1'b1;
							end
						end
						odtzq_pkg::ODTZQ_C_REFRESH: begin
							s_nxt.cmd       = i_req_cmd;
							s_nxt.ack       = 1'b1;
							s_nxt.refpd_cnt = REF_PD;
						end
						odtzq_pkg::ODTZQ_C_PD_ENTER: begin
							if (pd_ok) begin
								s_nxt.cmd    = i_req_cmd;
								s_nxt.ack    = 1'b1;
								s_nxt.cke    = 1'b0;
								s_nxt.stable = 4'h0;
								s_nxt.st     = odtzq_pkg::ODTZQ_S_PD;
							end
						end
						default: begin
						end
					endcase
				end
			end
			odtzq_pkg::ODTZQ_S_LVL_EN: begin
				if (timer_done) begin
					s_nxt.dqs_oe_n = 1'b0;
					timer_load     = 1'b1;
					timer_val      = LVL_STB;
					s_nxt.st       = odtzq_pkg::ODTZQ_S_LVL_PL;
				end
			end
			odtzq_pkg::ODTZQ_S_LVL_PL: begin
				if (timer_done) begin
					s_nxt.dqs   = 1'b1;
					s_nxt.ready = 1'b1;
					s_nxt.st    = odtzq_pkg::ODTZQ_S_IDLE;
				end
			end
			odtzq_pkg::ODTZQ_S_PD: begin
				if (take && i_req_cmd == odtzq_pkg::ODTZQ_C_PD_EXIT) begin
					s_nxt.cmd     = i_req_cmd;
					s_nxt.ack     = 1'b1;
					s_nxt.cke     = 1'b1;
					s_nxt.stable  = 4'h0;
					// Frozen loop may need this even after refresh spacing
					s_nxt.dll_cnt = dll_exit_cyc;
					s_nxt.st      = odtzq_pkg::ODTZQ_S_IDLE;
				end
			end
			default: begin
				s_nxt.st = odtzq_pkg::ODTZQ_S_INIT;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r          <= '0;
			s_r.st       <= odtzq_pkg::ODTZQ_S_INIT;
			s_r.cmd      <= odtzq_pkg::ODTZQ_C_NOP;
			s_r.dqs_oe_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_ready    = s_r.ready;
	assign o_ack      = s_r.ack;
	assign o_cmd      = s_r.cmd;
	assign o_cke      = s_r.cke;
	assign o_odt      = s_r.odt;
	assign o_dqs      = s_r.dqs;
	assign o_dqs_oe_n = s_r.dqs_oe_n;

endmodule // odtzq_ctrl

// ---- odtzq_ctrl_assertions.sv ----
// Pin timing checks for the termination and calibration host.
// Assumes binding to odtzq_ctrl; one clock, async active-low reset.
`timescale 1ns/1ps

module odtzq_chk (
	// Clock and reset
	input wire logic                  i_core_clk,
	input wire logic                  i_rst_n,
	// User request
	input wire logic                  i_req_valid,
	input wire odtzq_pkg::odtzq_cmd_t i_req_cmd,
	input wire logic                  i_req_full_burst,
	input wire logic [3:0]            i_write_latency,
	input wire logic                  o_ready,
	input wire logic                  o_ack,
	// Device pins
	input wire odtzq_pkg::odtzq_cmd_t o_cmd,
	input wire logic                  o_cke,
	input wire logic                  o_odt,
	input wire logic                  o_dqs,
	input wire logic                  o_dqs_oe_n
);
	logic [9:0]            gap_r;
	logic [9:0]            up_r;
	logic [9:0]            st_r;
	logic                  odt_q_r;
	odtzq_pkg::odtzq_cmd_t last_r;
	logic [9:0]            wl;

	assign wl = {6'h00, i_write_latency};

	// Saturating, so one long idle spell never wraps into a false gap
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_r <= 10'h000;
			up_r <= 10'h000;
			st_r <= 10'h000;
			odt_q_r <= 1'b0;
			last_r <= odtzq_pkg::ODTZQ_C_NOP;
		end else begin
			odt_q_r <= o_odt;
			up_r <= (up_r == 10'h3ff) ? up_r : up_r + 10'h001;
			st_r <= (o_odt != odt_q_r) ? 10'h001 :
				(st_r == 10'h3ff) ? st_r : st_r + 10'h001;
			if (o_cmd != odtzq_pkg::ODTZQ_C_NOP) begin
				gap_r <= 10'h001;
				last_r <= o_cmd;
			end else if (gap_r != 10'h3ff) begin
				gap_r <= gap_r + 10'h001;
			end
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_odt_full_high: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_WRITE && $past(i_req_full_burst)
		|-> o_odt [*6] ##1 !o_odt)
		else $error("odt full pulse width wrong");
	a_odt_chop_high: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_WRITE && !$past(i_req_full_burst)
		|-> o_odt [*4] ##1 !o_odt)
		else $error("odt chop pulse width wrong");
	a_zq_init_wait: assert property (
		o_cmd != odtzq_pkg::ODTZQ_C_NOP &&
		last_r == odtzq_pkg::ODTZQ_C_ZQ_INIT |-> gap_r >= 10'h200)
		else $error("command too soon after init calibration");
	a_zq_long_wait: assert property (
		o_cmd != odtzq_pkg::ODTZQ_C_NOP &&
		last_r == odtzq_pkg::ODTZQ_C_ZQ_LONG |-> gap_r >= 10'h100)
		else $error("command too soon after long calibration");
	a_zq_short_wait: assert property (
		o_cmd != odtzq_pkg::ODTZQ_C_NOP &&
		last_r == odtzq_pkg::ODTZQ_C_ZQ_SHORT |-> gap_r >= 10'h040)
		else $error("command too soon after short calibration");
	a_lvl_strobe_delay: assert property (
		$rose(o_dqs) |->
		last_r == odtzq_pkg::ODTZQ_C_LVL && gap_r >= 10'h028)
		else $error("leveling strobe too early");
	a_lvl_drive_delay: assert property (
		$fell(o_dqs_oe_n) |->
		last_r == odtzq_pkg::ODTZQ_C_LVL && gap_r >= 10'h019)
		else $error("strobe drivers enabled too early");
	a_dll_lock_gate: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_READ ||
		o_cmd == odtzq_pkg::ODTZQ_C_WRITE |-> up_r >= 10'h200 &&
		!(last_r == odtzq_pkg::ODTZQ_C_PD_EXIT && gap_r < 10'h00a))
		else $error("locked-loop command too early");
	a_pd_odt_stable: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_PD_ENTER |->
		!o_odt && st_r >= wl - 10'h001)
		else $error("odt not stable before power-down");
	a_wr_pd_spacing: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_PD_ENTER &&
		last_r == odtzq_pkg::ODTZQ_C_WRITE |-> gap_r >= wl + 10'h005)
		else $error("power-down too soon after write");
	a_ack_with_cmd: assert property (
		o_ack == (o_cmd != odtzq_pkg::ODTZQ_C_NOP &&
		o_cmd != odtzq_pkg::ODTZQ_C_ZQ_INIT))
		else $error("ack and command disagree");
	a_cal_not_ready: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_ZQ_LONG ||
		o_cmd == odtzq_pkg::ODTZQ_C_ZQ_SHORT ||
		o_cmd == odtzq_pkg::ODTZQ_C_LVL |-> !o_ready)
		else $error("ready during calibration or leveling");
	a_cke_pd_entry: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_PD_ENTER |-> !o_cke)
		else $error("clock enable high at power-down entry");
	a_cke_pd_exit: assert property (
		o_cmd == odtzq_pkg::ODTZQ_C_PD_EXIT |-> o_cke)
		else $error("clock enable low at power-down exit");
	a_pd_no_cmd: assert property (
		!o_cke |-> o_cmd == odtzq_pkg::ODTZQ_C_NOP ||
		o_cmd == odtzq_pkg::ODTZQ_C_PD_ENTER)
		else $error("command issued during power-down");
endmodule // odtzq_chk

// ---- odtzq_defs.svh ----
// Timing constants for the termination, calibration and leveling host.
// Assumes a 40 MHz controller clock equal to the memory command clock.
// Overview of operation
// - Hold termination input stable WL-1 around power-down
// - Termination high four cycles, none or chopped
// - Termination high six cycles for full bursts
// - Wait 512 cycles for initial calibration
// - Wait 256 cycles after long calibration
// - Wait 64 cycles after short calibration
// - First leveling strobe 40 cycles after enable
// - Enable strobe drivers 25 cycles after enable
// - Reads and termination need locked delay loop
// - Power-down entry waits for pending write, refresh and termination
// - Allow frozen-loop exit delay after power-down exit
// - Round write recovery up to whole cycles
// - Use larger of nanosecond and cycle figures
`ifndef ODTZQ_DEFS_SVH
`define ODTZQ_DEFS_SVH

`define ODTZQ_CLK_PERIOD_NS       25
`define ODTZQ_INIT_CAL_NCK        512
`define ODTZQ_LONG_CAL_NCK        256
`define ODTZQ_SHORT_CAL_NCK       64
`define ODTZQ_LVL_STROBE_EN_NCK   25
`define ODTZQ_LVL_FIRST_STB_NCK   40
`define ODTZQ_TERM_HIGH_SHORT_NCK 4
`define ODTZQ_TERM_HIGH_FULL_NCK  6
`define ODTZQ_TERM_PD_WL_SUB      1
`define ODTZQ_WR_PD_BURST_NCK     4
`define ODTZQ_WR_REC_NS           15
`define ODTZQ_WR_REC_NCK          1
`define ODTZQ_DLL_LOCK_NCK        512
`define ODTZQ_DLL_EXIT_NS         24
`define ODTZQ_DLL_EXIT_NCK        10
`define ODTZQ_REF_PD_NCK          1
`define ODTZQ_STABLE_MAX          15

`endif

// ---- odtzq_dev.sv ----
// Device model: termination switching and internal write start.
// Assumes host pins sampled on the same clock; no data path.
`timescale 1ns/1ps

module odtzq_dev (
	// Clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	// Host pins
	input  wire odtzq_pkg::odtzq_cmd_t i_cmd,
	input  wire logic                  i_odt,
	input  wire logic [3:0]            i_wl,
	// Internal state
	output logic                       o_term_on,
	output logic                       o_wr_start
);
	logic [15:0] odt_pipe_r;
	logic [15:0] wr_pipe_r;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			odt_pipe_r <= 16'h0000;
			wr_pipe_r <= 16'h0000;
		end else begin
			odt_pipe_r <= {odt_pipe_r[14:0], i_odt};
			wr_pipe_r <= {wr_pipe_r[14:0], i_cmd == odtzq_pkg::ODTZQ_C_WRITE};
		end
	end

	// One delay for on, off and switch, so write ends with the pulse
	assign o_term_on = odt_pipe_r[i_wl - 4'h3];
	assign o_wr_start = wr_pipe_r[i_wl + 4'h3];
endmodule // odtzq_dev

// ---- odtzq_pkg.sv ----
// Types and cycle arithmetic for the termination/calibration host.
// Assumes odtzq_defs.svh is on the include path.
`include "odtzq_defs.svh"

package odtzq_pkg;

	typedef enum logic [3:0] {
		ODTZQ_C_NOP      = 4'h0,
		ODTZQ_C_ZQ_LONG  = 4'h1,
		ODTZQ_C_ZQ_SHORT = 4'h2,
		ODTZQ_C_LVL      = 4'h3,
		ODTZQ_C_WRITE    = 4'h4,
		ODTZQ_C_READ     = 4'h5,
		ODTZQ_C_REFRESH  = 4'h6,
		ODTZQ_C_PD_ENTER = 4'h7,
		ODTZQ_C_PD_EXIT  = 4'h8,
		ODTZQ_C_ZQ_INIT  = 4'h9
	} odtzq_cmd_t;

	// Gray along init, wait, idle, leveling, power-down
	typedef enum logic [2:0] {
		ODTZQ_S_INIT   = 3'h0,
		ODTZQ_S_WAIT   = 3'h1,
		ODTZQ_S_IDLE   = 3'h3,
		ODTZQ_S_LVL_EN = 3'h2,
		ODTZQ_S_LVL_PL = 3'h6,
		ODTZQ_S_PD     = 3'h7
	} odtzq_state_t;

	typedef struct packed {
		odtzq_state_t st;
		odtzq_cmd_t   cmd;
		logic         ack;
		logic         ready;
		logic         cke;
		logic         odt;
		logic         dqs;
		logic         dqs_oe_n;
		logic [9:0]   dll_cnt;
		logic [3:0]   odt_cnt;
		logic [4:0]   wrpd_cnt;
		logic [1:0]   refpd_cnt;
		logic [3:0]   stable;
	} odtzq_ctrl_t;

	typedef struct packed {
		logic [9:0] cnt;
	} odtzq_timer_t;

	// Larger of a rounded-up ns figure and a cycle figure
	function automatic logic [9:0] odtzq_ns_to_cyc(input int unsigned ns,
		input int unsigned nck);
		int unsigned c;
		c = (ns + `ODTZQ_CLK_PERIOD_NS - 1) / `ODTZQ_CLK_PERIOD_NS;
		if (nck > c) begin
			c = nck;
		end
		return c[9:0];
	endfunction

endpackage

// ---- odtzq_timer.sv ----
// Loadable down counter used for calibration and leveling waits.
// Assumes one clock domain and asynchronous active-low reset.
`timescale 1ns/1ps

module odtzq_timer (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// Load
	input  wire logic       i_load,
	input  wire logic [9:0] i_value,
	// Status
	output logic            o_done
);

	odtzq_pkg::odtzq_timer_t s_r;
	odtzq_pkg::odtzq_timer_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (i_load) begin
			s_nxt.cnt = i_value;
		end else if (s_r.cnt != 10'h000) begin
			s_nxt.cnt = s_r.cnt - 10'h001;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_done = (s_r.cnt == 10'h000);

endmodule // odtzq_timer

// ---- test_odt_zq_wrlevel_timing.sv ----
// Self-checking bench for the termination and calibration host.
// Assumes package, design, checker and device model compiled first.
`timescale 1ns/1ps

module test_odt_zq_wrlevel_timing;
	logic                  i_core_clk = 1'b0;
	logic                  i_rst_n = 1'b0;
	logic                  i_req_valid = 1'b0;
	odtzq_pkg::odtzq_cmd_t i_req_cmd = odtzq_pkg::ODTZQ_C_NOP;
	logic                  i_req_full_burst = 1'b0;
	logic [3:0]            i_write_latency = 4'h6;
	logic                  o_ready, o_ack, o_cke, o_odt, o_dqs, o_dqs_oe_n;
	logic                  term_on, wr_start;
	odtzq_pkg::odtzq_cmd_t o_cmd, exp_cmd;
	odtzq_pkg::odtzq_cmd_t exp_q[$];
	odtzq_pkg::odtzq_cmd_t seq[10];
	int                    failures = 0;
	int                    num_checks = 0;
	int                    cyc = 0;
	int                    seed = 32'h07b1ccb9;
	logic                  odt_prev = 1'b0;
	logic                  term_prev = 1'b0;
	int                    term_due_q[$];
	int                    wr_due_q[$];
	int                    due;

	always #12.5 i_core_clk = ~i_core_clk;

	odtzq_ctrl odtzq_ctrl_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
		.i_req_full_burst(i_req_full_burst),
		.i_write_latency(i_write_latency), .o_ready(o_ready),
		.o_ack(o_ack), .o_cmd(o_cmd), .o_cke(o_cke), .o_odt(o_odt),
		.o_dqs(o_dqs), .o_dqs_oe_n(o_dqs_oe_n));
	odtzq_dev odtzq_dev_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_cmd(o_cmd), .i_odt(o_odt), .i_wl(i_write_latency),
		.o_term_on(term_on), .o_wr_start(wr_start));

	task automatic wrap_up();
		if (failures == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Held until acked; a request never taken ends the run
	task automatic req(input odtzq_pkg::odtzq_cmd_t c, input logic fb);
		int n;
		n = 0;
		@(negedge i_core_clk);
		i_req_valid = 1'b1;
		i_req_cmd = c;
		i_req_full_burst = (c == odtzq_pkg::ODTZQ_C_WRITE) ? fb :
			1'($random(seed));
		exp_q.push_back(c);
		while (o_ack !== 1'b1 && n < 2000) begin
			@(negedge i_core_clk);
			n++;
		end
		i_req_valid = 1'b0;
		if (o_ack !== 1'b1) begin
			failures++;
			$display("mismatch o_ack expected 1 seen %0b", o_ack);
			wrap_up();
		end
	endtask

	always @(negedge i_core_clk) begin
		if (i_rst_n && o_cmd !== odtzq_pkg::ODTZQ_C_NOP) begin
			exp_cmd = (exp_q.size() > 0) ? exp_q.pop_front() :
				odtzq_pkg::ODTZQ_C_NOP;
			num_checks++;
			if (o_cmd !== exp_cmd) begin
				failures++;
				$display("mismatch o_cmd expected %0h seen %0h", exp_cmd, o_cmd);
			end
		end
	end

	// Device latencies counted from the host pin change
	always @(negedge i_core_clk) begin
		if (i_rst_n) begin
			if (o_odt !== odt_prev) begin
				term_due_q.push_back(cyc + int'(i_write_latency) - 2);
			end
			if (o_cmd === odtzq_pkg::ODTZQ_C_WRITE) begin
				wr_due_q.push_back(cyc + int'(i_write_latency) + 4);
			end
			if (term_on !== term_prev) begin
				due = (term_due_q.size() > 0) ? term_due_q.pop_front() : -1;
				num_checks++;
				if (cyc != due) begin
					failures++;
					$display("mismatch term_on expected %0d seen %0d", due, cyc);
				end
			end
			if (wr_start !== 1'b0) begin
				due = (wr_due_q.size() > 0) ? wr_due_q.pop_front() : -1;
				num_checks++;
				if (cyc != due) begin
					failures++;
					$display("mismatch wr_start expected %0d seen %0d", due, cyc);
				end
			end
		end
		odt_prev = o_odt;
		term_prev = term_on;
	end

	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		seq = '{odtzq_pkg::ODTZQ_C_WRITE, odtzq_pkg::ODTZQ_C_READ,
			odtzq_pkg::ODTZQ_C_REFRESH, odtzq_pkg::ODTZQ_C_ZQ_SHORT,
			odtzq_pkg::ODTZQ_C_ZQ_LONG, odtzq_pkg::ODTZQ_C_LVL,
			odtzq_pkg::ODTZQ_C_WRITE, odtzq_pkg::ODTZQ_C_PD_ENTER,
			odtzq_pkg::ODTZQ_C_PD_EXIT, odtzq_pkg::ODTZQ_C_READ};
		i_write_latency = 4'h5 + 4'($random(seed) & 3);
		exp_q.push_back(odtzq_pkg::ODTZQ_C_ZQ_INIT);
		repeat (20) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_rst_n = 1'b1;
		// First write full burst, second chopped
		foreach (seq[k]) req(seq[k], k == 0);
		// Exit while idle must be ignored: no command may appear
		@(negedge i_core_clk);
		i_req_cmd = odtzq_pkg::ODTZQ_C_PD_EXIT;
		i_req_valid = 1'b1;
		repeat (30) @(negedge i_core_clk);
		i_req_valid = 1'b0;
		// Mid-run reset restarts init calibration and loop lock
		i_rst_n = 1'b0;
		repeat (3) @(negedge i_core_clk);
		exp_q.push_back(odtzq_pkg::ODTZQ_C_ZQ_INIT);
		i_rst_n = 1'b1;
		req(odtzq_pkg::ODTZQ_C_READ, 1'b0);
		repeat (5) @(negedge i_core_clk);
		due = exp_q.size() + term_due_q.size() + wr_due_q.size();
		num_checks++;
		if (due != 0) begin
			failures++;
			$display("mismatch pending expected 0 seen %0d", due);
		end
		wrap_up();
	end
endmodule // test_odt_zq_wrlevel_timing

bind odtzq_ctrl odtzq_chk odtzq_chk_i (.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
	.i_req_full_burst(i_req_full_burst), .i_write_latency(i_write_latency),
	.o_ready(o_ready), .o_ack(o_ack), .o_cmd(o_cmd), .o_cke(o_cke),
	.o_odt(o_odt), .o_dqs(o_dqs), .o_dqs_oe_n(o_dqs_oe_n));
